// file: rtl/rxcc_defines.svh
// Purpose: constants of the receive channel conditioner
// Assumes: 20 MHz system clock
// Notes:   definitions only
`ifndef RXCC_DEFINES_SVH
`define RXCC_DEFINES_SVH
// register offsets
`define RXCC_OFF_CONFIG      8'h50
`define RXCC_OFF_STATUS      8'h51
`define RXCC_OFF_ADDR_CTRL   8'h52
`define RXCC_OFF_DATA_BUF    8'h53
`define RXCC_RESET_BYTE      8'h00
// field positions
`define RXCC_CFG_CHAN_EN_BIT 0
`define RXCC_CFG_MODE_BIT    1
`define RXCC_STAT_BUSY_BIT   7
`define RXCC_AC_DIR_BIT      7
`define RXCC_CTRL_FULL_BIT   7
`define RXCC_CTRL_COND_BIT   6
`define RXCC_CTRL_MW_BIT     5
`define RXCC_CTRL_MSB_BIT    4
`define RXCC_SIG_COND_BIT    7
// internal table layout
`define RXCC_NUM_CHAN        5'd24
`define RXCC_TBL_SIZE        72
`define RXCC_ADDR_FIRST      7'h01
`define RXCC_ADDR_LAST       7'h48
`define RXCC_CODE_OFS        7'h18
`define RXCC_SIG_OFS         7'h30
`define RXCC_CTRL_WR_MASK    8'hF0
`define RXCC_CODE_WR_MASK    8'hFF
`define RXCC_SIG_WR_MASK     8'h8F
// milliwatt sequence, first byte in the top lane
`define RXCC_MW_PATTERN      64'h1E0B0B1E9E8B8B9E
// timing
`define RXCC_CLK_PERIOD_NS   50
`define RXCC_ACCESS_MAX_NS   640
`define RXCC_ACCESS_MAX_CYC  (`RXCC_ACCESS_MAX_NS / `RXCC_CLK_PERIOD_NS)
`define RXCC_SERVICE_CYC     4'h3
`endif

// file: rtl/rxcc_pkg.sv
// Purpose: types of the receive channel conditioner
// Assumes: nothing
// Notes:   constants live in rxcc_defines.svh
`default_nettype none
package rxcc_pkg;
    typedef logic [7:0] rxcc_byte_t;
    // indirect access sequencer
    typedef enum logic [1:0] {
        RXCC_IDLE   = 2'b00,
        RXCC_ACCESS = 2'b01
    } rxcc_state_e;
endpackage
`default_nettype wire

// file: rtl/rxcc_rx_channel_conditioner.sv
// Purpose: per-channel receive PCM and signaling conditioning
// Assumes: stream and cpu strobes on clk_sys_in
// Notes:   bytes are parallel; bit 7 is the first bit on the wire
`include "rxcc_defines.svh"
`default_nettype none

module rxcc_rx_channel_conditioner (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_b_in,
    // microprocessor port
    input  wire logic [7:0] cpu_addr_in,
    input  wire logic       cpu_wr_in,
    input  wire logic       cpu_rd_in,
    input  wire logic [7:0] cpu_wdata_in,
    output logic      [7:0] cpu_rdata_out,
    // received stream from the framer
    input  wire logic [7:0] rx_pcm_in,
    input  wire logic [7:0] rx_sig_in,
    input  wire logic [4:0] rx_chan_in,
    input  wire logic       rx_valid_in,
    output logic            rx_ready_out,
    // conditioned stream to the backplane
    output logic      [7:0] receive_pcm_out,
    output logic      [7:0] receive_sig_out,
    output logic      [4:0] receive_chan_out,
    output logic            receive_valid_out,
    input  wire logic       receive_ready_in
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    rxcc_pkg::rxcc_state_e st_q;
    logic                  chan_en_q;
    logic                  indirect_mode_q;
    logic            [7:0] addr_ctrl_q;
    rxcc_pkg::rxcc_byte_t  data_buf_q;
    rxcc_pkg::rxcc_byte_t  rdata_q;
    logic            [3:0] svc_cnt_q;
    rxcc_pkg::rxcc_byte_t  tbl_q [0:`RXCC_TBL_SIZE-1];
    logic            [2:0] mw_ph_q;
    logic           [20:0] fifo_q [0:1];
    logic                  wr_ptr_q;
    logic                  rd_ptr_q;
    logic            [1:0] cnt_q;

    logic                  busy;
    logic                  req_start;
    logic                  acc_done;
    logic                  acc_dir;
    logic                  acc_valid;
    logic            [6:0] acc_idx;
    logic                  tbl_wr;
    rxcc_pkg::rxcc_byte_t  wr_mask;
    rxcc_pkg::rxcc_byte_t  tbl_at_addr;
    logic                  chan_ok;
    logic            [6:0] ch_sel;
    rxcc_pkg::rxcc_byte_t  ctrl_b;
    rxcc_pkg::rxcc_byte_t  code_b;
    rxcc_pkg::rxcc_byte_t  sig_b;
    rxcc_pkg::rxcc_byte_t  mw_byte;
    rxcc_pkg::rxcc_byte_t  pcm_d;
    rxcc_pkg::rxcc_byte_t  sig_d;
    logic                  push;
    logic                  pop;

    // ----------------------------------------
    // indirect access decode
    // ----------------------------------------
    // a request while busy is dropped so the running access stays intact
    assign busy      = (st_q != rxcc_pkg::RXCC_IDLE);
    assign req_start = cpu_wr_in && (cpu_addr_in == `RXCC_OFF_ADDR_CTRL)
                       && !busy;
    assign acc_done  = (st_q == rxcc_pkg::RXCC_ACCESS) && (svc_cnt_q == 4'h0);
    assign acc_dir   = addr_ctrl_q[`RXCC_AC_DIR_BIT];
    assign acc_valid = (addr_ctrl_q[6:0] >= `RXCC_ADDR_FIRST)
                       && (addr_ctrl_q[6:0] <= `RXCC_ADDR_LAST);
    assign acc_idx   = acc_valid ? (addr_ctrl_q[6:0] - 7'h01) : 7'h00;
    assign tbl_wr    = acc_done && !acc_dir && acc_valid;
    assign tbl_at_addr = acc_valid ? tbl_q[acc_idx] : `RXCC_RESET_BYTE;

    // per-region write mask, matching the generate below
    always_comb begin
        if (acc_idx < `RXCC_CODE_OFS) begin
            wr_mask = `RXCC_CTRL_WR_MASK;
        end else if (acc_idx < `RXCC_SIG_OFS) begin
            wr_mask = `RXCC_CODE_WR_MASK;
        end else begin
            wr_mask = `RXCC_SIG_WR_MASK;
        end
    end

    // ----------------------------------------
    // access sequencer
    // ----------------------------------------
    // fixed service time, well inside the 640 ns bound
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            st_q      <= rxcc_pkg::RXCC_IDLE;
            svc_cnt_q <= 4'h0;
        end else begin
            case (st_q)
                rxcc_pkg::RXCC_IDLE: begin
                    if (req_start) begin
                        st_q      <= rxcc_pkg::RXCC_ACCESS;
                        svc_cnt_q <= `RXCC_SERVICE_CYC;
                    end
                end
                rxcc_pkg::RXCC_ACCESS: begin
                    if (svc_cnt_q == 4'h0) begin
                        st_q <= rxcc_pkg::RXCC_IDLE;
                    end else begin
                        svc_cnt_q <= svc_cnt_q - 4'h1;
                    end
                end
                default: begin
                    st_q <= rxcc_pkg::RXCC_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    // configuration: channel enable and indirect mode
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            chan_en_q       <= 1'b0;
            indirect_mode_q <= 1'b0;
        end else if (cpu_wr_in && (cpu_addr_in == `RXCC_OFF_CONFIG)) begin
            chan_en_q       <= cpu_wdata_in[`RXCC_CFG_CHAN_EN_BIT];
            indirect_mode_q <= cpu_wdata_in[`RXCC_CFG_MODE_BIT];
        end
    end

    // address/control, taken only when idle
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            addr_ctrl_q <= `RXCC_RESET_BYTE;
        end else if (req_start) begin
            addr_ctrl_q <= cpu_wdata_in;
        end
    end

    // data buffer; a completing read wins over a cpu write
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            data_buf_q <= `RXCC_RESET_BYTE;
        end else if (acc_done && acc_dir) begin
            data_buf_q <= tbl_at_addr;
        end else if (cpu_wr_in && (cpu_addr_in == `RXCC_OFF_DATA_BUF)) begin
            data_buf_q <= cpu_wdata_in;
        end
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rdata_q <= `RXCC_RESET_BYTE;
        end else if (cpu_rd_in) begin
            case (cpu_addr_in)
                `RXCC_OFF_CONFIG:    rdata_q <= {6'h00, indirect_mode_q, chan_en_q};
                `RXCC_OFF_STATUS:    rdata_q <= {busy, 7'h00};
                `RXCC_OFF_ADDR_CTRL: rdata_q <= addr_ctrl_q;
                `RXCC_OFF_DATA_BUF:  rdata_q <= data_buf_q;
                default:             rdata_q <= `RXCC_RESET_BYTE;
            endcase
        end
    end
    assign cpu_rdata_out = rdata_q;

    // ----------------------------------------
    // per-channel table
    // ----------------------------------------
    // flops rather than ram so every entry is defined after reset
    for (genvar gi = 0; gi < `RXCC_TBL_SIZE; gi++) begin : g_tbl
        localparam logic [7:0] MASK = (gi < 24) ? `RXCC_CTRL_WR_MASK :
                                      (gi < 48) ? `RXCC_CODE_WR_MASK :
                                      `RXCC_SIG_WR_MASK;
        always_ff @(posedge clk_sys_in) begin
            if (!rst_b_in) begin
                tbl_q[gi] <= `RXCC_RESET_BYTE;
            end else if (tbl_wr && (acc_idx == 7'(gi))) begin
                tbl_q[gi] <= data_buf_q & MASK;
            end
        end
    end

    // ----------------------------------------
    // channel conditioning
    // ----------------------------------------
    // out-of-range channels (framing slots) read entry 0 but are not altered
    assign chan_ok = (rx_chan_in != 5'h00) && (rx_chan_in <= `RXCC_NUM_CHAN);
    assign ch_sel  = chan_ok ? {2'b00, rx_chan_in - 5'h01} : 7'h00;
    assign ctrl_b  = tbl_q[ch_sel];
    assign code_b  = tbl_q[ch_sel + `RXCC_CODE_OFS];
    assign sig_b   = tbl_q[ch_sel + `RXCC_SIG_OFS];
    assign mw_byte = 8'(`RXCC_MW_PATTERN >> {3'h7 - mw_ph_q, 3'h0});

    // no framing format input: behaviour is format independent
    always_comb begin
        pcm_d = rx_pcm_in;
        sig_d = rx_sig_in;
        if (chan_en_q && chan_ok) begin
            if (ctrl_b[`RXCC_CTRL_MW_BIT]) begin
                pcm_d = mw_byte;
            end else if (ctrl_b[`RXCC_CTRL_COND_BIT]) begin
                pcm_d = code_b;
            end else if (ctrl_b[`RXCC_CTRL_FULL_BIT] && ctrl_b[`RXCC_CTRL_MSB_BIT]) begin
                pcm_d = {rx_pcm_in[7], ~rx_pcm_in[6:0]};
            end else if (ctrl_b[`RXCC_CTRL_FULL_BIT]) begin
                pcm_d = ~rx_pcm_in;
            end else if (ctrl_b[`RXCC_CTRL_MSB_BIT]) begin
                pcm_d = {~rx_pcm_in[7], rx_pcm_in[6:0]};
            end
            if (sig_b[`RXCC_SIG_COND_BIT]) begin
                sig_d = {rx_sig_in[7:4], sig_b[3:0]};
            end
        end
    end

    // milliwatt phase steps once per frame, after the last channel
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            mw_ph_q <= 3'h0;
        end else if (push && (rx_chan_in == `RXCC_NUM_CHAN)) begin
            mw_ph_q <= mw_ph_q + 3'h1;
        end
    end

    // ----------------------------------------
    // two-entry output buffer
    // ----------------------------------------
    // a backplane stall holds the framer instead of dropping bytes
    assign rx_ready_out      = (cnt_q != 2'h2);
    assign receive_valid_out = (cnt_q != 2'h0);
    assign push              = rx_valid_in && rx_ready_out;
    assign pop               = receive_valid_out && receive_ready_in;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            fifo_q[0] <= 21'h000000;
            fifo_q[1] <= 21'h000000;
            wr_ptr_q  <= 1'b0;
        end else if (push) begin
            fifo_q[wr_ptr_q] <= {rx_chan_in, sig_d, pcm_d};
            wr_ptr_q         <= ~wr_ptr_q;
        end
    end

    // read pointer and fill level
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rd_ptr_q <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    assign receive_pcm_out  = fifo_q[rd_ptr_q][7:0];
    assign receive_sig_out  = fifo_q[rd_ptr_q][15:8];
    assign receive_chan_out = fifo_q[rd_ptr_q][20:16];

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_req_sets_busy: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        cpu_wr_in && (cpu_addr_in == `RXCC_OFF_ADDR_CTRL) && !busy |=> busy)
        else $error("access request did not raise busy");

    a_busy_bounded: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $rose(busy) |-> busy [*4] ##1 !busy)
        else $error("busy did not fall on time");

    a_read_fills_buf: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $rose(busy) && acc_dir |-> ##[1:12] (!busy && data_buf_q == tbl_at_addr))
        else $error("read data not in buffer within 640 ns");

    a_write_stores: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        tbl_wr |=> tbl_at_addr == ($past(data_buf_q) & $past(wr_mask)))
        else $error("table write stored wrong value");

    a_mw_priority: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        push && chan_en_q && chan_ok && ctrl_b[5] |=> fifo_q[$past(wr_ptr_q)][7:0] == $past(mw_byte))
        else $error("milliwatt not inserted");

    a_code_subst: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        push && chan_en_q && chan_ok && !ctrl_b[5] && ctrl_b[6] |-> pcm_d == code_b)
        else $error("conditioning code not substituted");

    a_inversions: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        push && chan_en_q && chan_ok && (ctrl_b[6:5] == 2'b00)
        |-> pcm_d == (rx_pcm_in ^ {ctrl_b[7] ^ ctrl_b[4], {7{ctrl_b[7]}}}))
        else $error("inversion pattern wrong");

    a_pass_disabled: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        push && !chan_en_q |-> (pcm_d == rx_pcm_in) && (sig_d == rx_sig_in))
        else $error("data altered while disabled");

    a_sig_nibble: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        push && chan_en_q && chan_ok && sig_b[7] |-> sig_d == {rx_sig_in[7:4], sig_b[3:0]})
        else $error("signaling code not placed in low nibble");

    a_mw_step: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        push && (rx_chan_in == 5'd24) |=> mw_ph_q == 3'($past(mw_ph_q) + 3'h1))
        else $error("milliwatt phase did not advance");

    a_out_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        receive_valid_out && !receive_ready_in |=> receive_valid_out && $stable(receive_pcm_out))
        else $error("output changed while stalled");

endmodule // rxcc_rx_channel_conditioner
`default_nettype wire

// file: verif/rxcc_sink_model.sv
// Purpose: backplane consumer of the conditioned receive stream
// Assumes: one clock, synchronous active-low reset
// Notes:   every accepted byte is queued for the bench to compare
`default_nettype none

module rxcc_sink_model (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_b_in,
    // stream from the conditioner
    input  wire logic       valid_in,
    input  wire logic [7:0] pcm_in,
    input  wire logic [7:0] sig_in,
    input  wire logic [4:0] chan_in,
    output logic            ready_out,
    // bench control
    input  wire logic       stall_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [20:0] seen[$];

    // ready moves only after an edge, so a stall is seen one cycle late
    always @(posedge clk_sys_in) begin
        ready_out <= rst_b_in && !stall_in;
        if (rst_b_in && valid_in && ready_out) begin
            seen.push_back({chan_in, sig_in, pcm_in});
        end
    end
endmodule // rxcc_sink_model
`default_nettype wire

// file: verif/rxcc_rx_channel_conditioner_tb.sv
// Purpose: self-checking bench of the receive channel conditioner
// Assumes: inputs driven at the falling edge, 50 ns clock
// Notes:   a spare cycle separates strobes so none is set twice at once
`include "rxcc_defines.svh"
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

module rxcc_rx_channel_conditioner_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_sys_in = 0, rst_b_in = 0, cpu_wr = 0, cpu_rd = 0, rx_valid = 0, stall = 0;
    logic [7:0] cpu_addr = 0, cpu_wdata = 0, rx_pcm = 0, rx_sig = 0, rdata, pcm_o, sig_o, rd;
    logic [4:0] rx_chan = 0, chan_o;
    logic       rx_ready, v_o, ready_i;
    int         error_cnt = 0, checked = 0, cyc = 0;
    logic [7:0] offs[5] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54};
    logic [7:0] msk[3]  = '{8'hF0, 8'hFF, 8'h8F};
    logic [7:0] ctl[4]  = '{8'h00, 8'h80, 8'h10, 8'h90};
    logic [7:0] inv[4]  = '{8'hC3, 8'h3C, 8'h43, 8'hBC};

    rxcc_rx_channel_conditioner dut (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .cpu_addr_in(cpu_addr), .cpu_wr_in(cpu_wr),
        .cpu_rd_in(cpu_rd), .cpu_wdata_in(cpu_wdata), .cpu_rdata_out(rdata), .rx_pcm_in(rx_pcm),
        .rx_sig_in(rx_sig), .rx_chan_in(rx_chan), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
        .receive_pcm_out(pcm_o), .receive_sig_out(sig_o), .receive_chan_out(chan_o),
        .receive_valid_out(v_o), .receive_ready_in(ready_i));

    rxcc_sink_model sink (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .valid_in(v_o), .pcm_in(pcm_o), .sig_in(sig_o),
        .chan_in(chan_o), .ready_out(ready_i), .stall_in(stall));

    // clock and hang guard; a stuck handshake must not run forever
    initial forever #25 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // register port: one-cycle strobes
    task automatic cpu_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in); cpu_wr = 1; cpu_addr = a; cpu_wdata = d;
        @(negedge clk_sys_in); cpu_wr = 0;
    endtask
    task automatic cpu_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_in); cpu_rd = 1; cpu_addr = a;
        @(negedge clk_sys_in); cpu_rd = 0; d = rdata;
    endtask

    // busy must show at once and clear within 640 ns (two cycles a poll, last sample 600 ns)
    task automatic wait_idle();
        int n;
        logic [7:0] s;
        n = 0;
        cpu_read(8'h51, s);
        `CHK("busy_set", 1'b1, s[7])
        while (s[7] !== 1'b0 && n < 20) begin cpu_read(8'h51, s); n++; end
        `CHK("busy_bound", 1'b1, n <= 5)
    endtask
    task automatic indir_wr(input logic [6:0] a, input logic [7:0] d);
        cpu_write(8'h53, d);
        cpu_write(8'h52, {1'b0, a});
        wait_idle();
    endtask
    task automatic indir_rd(input logic [6:0] a, output logic [7:0] d);
        cpu_write(8'h52, {1'b1, a});
        wait_idle();
        cpu_read(8'h53, d);
    endtask

    // stream side
    task automatic send(input logic [4:0] c, input logic [7:0] p, input logic [7:0] s);
        int n;
        @(negedge clk_sys_in); rx_valid = 1; rx_chan = c; rx_pcm = p; rx_sig = s;
        n = 0;
        while (rx_ready !== 1'b1 && n < 50) begin @(negedge clk_sys_in); n++; end
        @(negedge clk_sys_in); rx_valid = 0;
    endtask
    task automatic take(input logic [20:0] e);
        int n;
        logic [20:0] g;
        n = 0;
        while (sink.seen.size() == 0 && n < 50) begin @(negedge clk_sys_in); n++; end
        g = (sink.seen.size() > 0) ? sink.seen.pop_front() : 'x;
        `CHK("stream_out", e, g)
    endtask

    // main sequence
    initial begin
        logic [6:0] a;
        logic [7:0] d;
        repeat (2) @(negedge clk_sys_in);
        rst_b_in = 1;
        foreach (offs[i]) begin cpu_read(offs[i], rd); `CHK("reset_reg", 8'h00, rd) end
        cpu_write(8'h50, 8'h03);
        cpu_read(8'h50, rd); `CHK("config", 8'h03, rd)
        // first and last channel of every table region, masked bits
        for (int k = 0; k < 2; k++) begin
            for (int t = 0; t < 3; t++) begin
                a = 7'(t * 24 + (k ? 24 : 1));
                d = 8'h80 | {1'b0, a};
                indir_wr(a, d);
                indir_rd(a, rd); `CHK("table_rw", d & msk[t], rd)
            end
        end
        indir_rd(7'h49, rd); `CHK("beyond_table", 8'h00, rd)
        indir_wr(7'h00, 8'h55);
        indir_rd(7'h00, rd); `CHK("addr_zero", 8'h00, rd)
        // second request while busy is dropped
        cpu_write(8'h52, 8'h81);
        cpu_write(8'h52, 8'h82);
        wait_idle();
        cpu_read(8'h52, rd); `CHK("busy_refuse", 8'h81, rd)
        cpu_read(8'h53, rd); `CHK("read_dir", 8'h80, rd)
        // inversion table on channel 2
        foreach (ctl[i]) begin
            indir_wr(7'h02, ctl[i]);
            send(5'd2, 8'hC3, 8'h55);
            take({5'd2, 8'h55, inv[i]});
        end
        // code is not a bit palindrome, so a reversed shift order shows
        indir_wr(7'h1A, 8'h5C);
        indir_wr(7'h02, 8'hD0);
        send(5'd2, 8'hC3, 8'h55);
        take({5'd2, 8'h55, 8'h5C});
        indir_wr(7'h02, 8'hF0);
        send(5'd2, 8'hC3, 8'h55);
        take({5'd2, 8'h55, 8'h1E});
        send(5'd24, 8'h00, 8'h00);
        take({5'd24, 8'h08, 8'h7F});
        send(5'd2, 8'hC3, 8'h55);
        take({5'd2, 8'h55, 8'h0B});
        indir_wr(7'h32, 8'h8A);
        send(5'd2, 8'hC3, 8'h73);
        take({5'd2, 8'h7A, 8'h0B});
        indir_wr(7'h32, 8'h0A);
        send(5'd2, 8'hC3, 8'h73);
        take({5'd2, 8'h73, 8'h0B});
        // slot 0 is no channel: channel 1 settings (invert, signaling code) must not leak in
        send(5'd0, 8'hC3, 8'h55);
        take({5'd0, 8'h55, 8'hC3});
        cpu_write(8'h50, 8'h02);
        indir_wr(7'h32, 8'h8A);
        send(5'd2, 8'hC3, 8'h73);
        take({5'd2, 8'h73, 8'hC3});
        // stalled consumer: buffer fills, third byte waits, order kept
        @(negedge clk_sys_in); stall = 1;
        repeat (2) @(negedge clk_sys_in);
        fork
            begin send(5'd3, 8'h11, 8'h01); send(5'd4, 8'h22, 8'h02); send(5'd5, 8'h33, 8'h03); end
            begin
                repeat (12) @(negedge clk_sys_in);
                `CHK("buf_full", 1'b0, rx_ready)
                `CHK("buf_valid", 1'b1, v_o)
                stall = 0;
            end
        join
        take({5'd3, 8'h01, 8'h11});
        take({5'd4, 8'h02, 8'h22});
        take({5'd5, 8'h03, 8'h33});
        repeat (4) @(negedge clk_sys_in);
        `CHK("buf_empty", 1'b0, v_o)
        end_sim();
    end
endmodule // rxcc_rx_channel_conditioner_tb
`default_nettype wire
